// *** hdl/mbsr_defs.vh ***
/*
  Constants for the motor bridge serial register bank: frame fields,
  register selects, bit positions, reset values and timing counts.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MBSR_DEFS_VH
`define MBSR_DEFS_VH

// Frame fields.
`define MBSR_DIR_BIT 15
`define MBSR_SEL_HI 14
`define MBSR_SEL_LO 13
`define MBSR_FRAME_BITS 16

// Register selects.
`define MBSR_SEL_IDENT 2'h0
`define MBSR_SEL_FLAGS 2'h1
`define MBSR_SEL_MASK 2'h2
`define MBSR_SEL_CONF 2'h3

// Status and mask bit positions.
`define MBSR_B_OT 0
`define MBSR_B_TW 1
`define MBSR_B_OC 2
`define MBSR_B_OL 3
`define MBSR_B_SHORT_TO_GROUND_OUT_ONE 4
`define MBSR_B_SHORT_TO_GROUND_OUT_TWO 5
`define MBSR_B_SHORT_TO_SUPPLY_OUT_ONE 6
`define MBSR_B_SHORT_TO_SUPPLY_OUT_TWO 7
`define MBSR_B_OV 8
`define MBSR_B_UV 9
`define MBSR_B_CPU 10
`define MBSR_B_FRM 11
`define MBSR_B_DOV 12

// Configuration bit positions.
`define MBSR_C_SOFT_INPUT_ONE 0
`define MBSR_C_SOFT_INPUT_TWO 1
`define MBSR_C_INPUT 2
`define MBSR_C_MODE 3
`define MBSR_C_EN 4
`define MBSR_C_SR_LO 5
`define MBSR_C_SR_HI 7
`define MBSR_C_IL_LO 8
`define MBSR_C_IL_HI 9
`define MBSR_C_AL 10
`define MBSR_C_TM 11
`define MBSR_C_CL 12

// Reset values and read-back header bits.
`define MBSR_MASK_RST 13'h06F1
`define MBSR_CONF_RST 13'h0D98
`define MBSR_HDR_FLAGS 3'h1
`define MBSR_HDR_MASK 3'h2
`define MBSR_HDR_CONF 3'h3

// Least pulse width on the enable and off pins, in ns, and clock period.
`define MBSR_PIN_PULSE_NS 1000
`define MBSR_CLK_NS 40
`define MBSR_PULSE_CYC ((`MBSR_PIN_PULSE_NS + `MBSR_CLK_NS - 1) / `MBSR_CLK_NS)

`endif

// *** hdl/mbsr_regs.v ***
/*
  Serial register bank of an H-bridge motor driver: fault flags with
  write-one-to-clear, fault pin mask, bridge configuration, framing checks
  and the output-control decode derived from them.
  Assumes a host serial master (mode 0, 16-bit frames, clock idle low) and
  raw fault levels from the analog supervisors, all asynchronous.
*/
`timescale 1ns/1ps
`include "mbsr_defs.vh"

module mbsr_regs #(
  parameter PULSE_CYC = `MBSR_PULSE_CYC // Least pin pulse in clocks.
) (
  input wire sys_clk, // 25 MHz system clock.
  input wire rstn, // Synchronous reset, active low.
  input wire spi_sclk, // Serial clock from host.
  input wire spi_cs_n, // Frame select from host, active low.
  input wire spi_mosi, // Serial data from host.
  output reg spi_miso, // Serial data to host.
  output wire spi_miso_oe, // High while the data pin is driven.
  input wire enable_pin, // Enable pin.
  input wire output_off_pin, // Output disable pin.
  input wire drive_pin_one, // First input pin.
  input wire drive_pin_two, // Second input pin.
  input wire [10:0] fault_raw, // Live fault levels, status bits 10..0.
  output wire fault_status_pin_n, // Fault pin, active low.
  output reg out_enable, // Outputs driven; low means tri-state.
  output reg out_one_high, // Output one high side on.
  output reg out_two_high, // Output two high side on.
  output reg ov_protect_active, // Overvoltage braking applied.
  output reg active_limit_on, // Active current limiting enabled.
  output reg open_load_check_on, // Open-load check enabled.
  output reg open_load_test_start, // One-cycle start of standby test.
  output reg blanking_adjust_on, // Blanking may follow thermal warning.
  output reg independent_shorts, // Shorts handled per output.
  output reg [1:0] current_limit_code, // Applied current-limit code.
  output reg [2:0] slew_code // Applied slew-rate code.
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg [10:0] fsync1_reg;
  reg [10:0] fault_reg;
  reg sclk_d_reg;
  reg cs_d_reg;
  reg en_d_reg;
  reg off_d_reg;

  wire sclk_s = sync2_reg[0];
  wire cs_n_s = sync2_reg[1];
  wire mosi_s = sync2_reg[2];
  wire en_s = sync2_reg[3];
  wire off_s = sync2_reg[4];

  // Two flops on every asynchronous input, then one delay for edges.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_reg <= 6'h02;
      sync2_reg <= 6'h02;
      fsync1_reg <= 11'h000;
      fault_reg <= 11'h000;
      sclk_d_reg <= 1'b0;
      cs_d_reg <= 1'b1;
      en_d_reg <= 1'b0;
      off_d_reg <= 1'b0;
    end else begin
      sync1_reg <= {drive_pin_two, output_off_pin, enable_pin, spi_mosi,
                    spi_cs_n, spi_sclk};
      sync2_reg <= sync1_reg;
      fsync1_reg <= fault_raw;
      fault_reg <= fsync1_reg;
      sclk_d_reg <= sclk_s;
      cs_d_reg <= cs_n_s;
      en_d_reg <= en_s;
      off_d_reg <= off_s;
    end
  end

  reg pin_one_reg;
  reg pin_one_s_reg;

  // Input pin one has its own pair of flops.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      pin_one_reg <= 1'b0;
      pin_one_s_reg <= 1'b0;
    end else begin
      pin_one_reg <= drive_pin_one;
      pin_one_s_reg <= pin_one_reg;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg;
  wire cs_fall = ~cs_n_s & cs_d_reg;
  wire cs_rise = cs_n_s & ~cs_d_reg;

  // ----------------------------------------------------------------
  // Pin pulse qualification for fault clearing
  // ----------------------------------------------------------------
  reg [7:0] en_low_cnt_reg;
  reg [7:0] off_high_cnt_reg;

  // Count how long enable sat low and the off pin sat high.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      en_low_cnt_reg <= 8'h00;
      off_high_cnt_reg <= 8'h00;
    end else begin
      if (en_s)
        en_low_cnt_reg <= 8'h00;
      else if (en_low_cnt_reg < PULSE_CYC[7:0])
        en_low_cnt_reg <= en_low_cnt_reg + 8'h01;
      if (!off_s)
        off_high_cnt_reg <= 8'h00;
      else if (off_high_cnt_reg < PULSE_CYC[7:0])
        off_high_cnt_reg <= off_high_cnt_reg + 8'h01;
    end
  end

  wire pin_clear = (en_s & ~en_d_reg & (en_low_cnt_reg >= PULSE_CYC[7:0])) |
    (~off_s & off_d_reg & (off_high_cnt_reg >= PULSE_CYC[7:0]));

  // ----------------------------------------------------------------
  // Serial frame engine
  // ----------------------------------------------------------------
  reg [15:0] rx_reg;
  reg [15:0] tx_reg;
  reg [7:0] bit_cnt_reg;
  reg [1:0] last_sel_reg;
  reg [11:0] flags_reg;
  reg [12:0] mask_reg;
  reg [12:0] conf_reg;

  // Read image of a register; headers in bits 15..13 as the host sees them.
  function [15:0] mbsr_image;
    input [1:0] sel;
    input [11:0] flags;
    input [12:0] mask;
    input [12:0] conf;
    begin
      case (sel)
        `MBSR_SEL_FLAGS: mbsr_image = {`MBSR_HDR_FLAGS, 1'b0, flags};
        `MBSR_SEL_MASK: mbsr_image = {`MBSR_HDR_MASK, mask};
        `MBSR_SEL_CONF: mbsr_image = {`MBSR_HDR_CONF, conf};
        default: mbsr_image = 16'h0000;
      endcase
    end
  endfunction

  // Reply image picked at frame start; its top bit goes out first.
  wire [15:0] tx_image = mbsr_image(last_sel_reg, flags_reg, mask_reg,
                                    conf_reg);
  wire frame_len_ok = (bit_cnt_reg != 8'h00) && (bit_cnt_reg[3:0] == 4'h0);
  wire [1:0] rx_sel = rx_reg[`MBSR_SEL_HI:`MBSR_SEL_LO];
  wire rx_write = rx_reg[`MBSR_DIR_BIT];
  wire frame_end = cs_rise;
  wire do_write = frame_end & frame_len_ok & rx_write;
  wire frame_error = frame_end & (~frame_len_ok |
    (rx_write & (rx_sel == `MBSR_SEL_IDENT)));

  // Shift in on rising, out on falling; reply is previously selected reg.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      rx_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      bit_cnt_reg <= 8'h00;
      last_sel_reg <= `MBSR_SEL_FLAGS;
      spi_miso <= 1'b0;
    end else begin
      if (cs_fall) begin
        bit_cnt_reg <= 8'h00;
        tx_reg <= tx_image;
        spi_miso <= tx_image[15];
      end else if (!cs_n_s) begin
        if (sclk_rise) begin
          rx_reg <= {rx_reg[14:0], mosi_s};
          bit_cnt_reg <= bit_cnt_reg + 8'h01;
        end
        if (sclk_fall) begin
          tx_reg <= {tx_reg[14:0], 1'b0};
          spi_miso <= tx_reg[14];
        end
      end
      if (frame_end & frame_len_ok)
        last_sel_reg <= rx_sel;
    end
  end

  assign spi_miso_oe = ~cs_n_s;

  // ----------------------------------------------------------------
  // Fault flags: live faults set, write one or pin edge clears
  // ----------------------------------------------------------------
  wire [11:0] wr_clear = (do_write && rx_sel == `MBSR_SEL_FLAGS) ?
    rx_reg[11:0] : 12'h000;
  wire [11:0] any_clear = wr_clear | {12{pin_clear}};
  wire [11:0] live = {frame_error, fault_reg};

  // Set wins over clear; a still-active fault stays latched.
  always @(posedge sys_clk) begin
    if (!rstn)
      flags_reg <= 12'h000;
    else
      flags_reg <= (flags_reg & ~any_clear) | live;
  end

  // ----------------------------------------------------------------
  // Mask and configuration registers
  // ----------------------------------------------------------------
  reg cl_d_reg;

  // Writes take the low 13 bits; header bits are not stored.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      mask_reg <= `MBSR_MASK_RST;
      conf_reg <= `MBSR_CONF_RST;
      cl_d_reg <= 1'b0;
    end else begin
      if (do_write && rx_sel == `MBSR_SEL_MASK)
        mask_reg <= rx_reg[12:0];
      if (do_write && rx_sel == `MBSR_SEL_CONF)
        conf_reg <= rx_reg[12:0];
      cl_d_reg <= conf_reg[`MBSR_C_CL];
    end
  end

  // ----------------------------------------------------------------
  // Output control decode
  // ----------------------------------------------------------------
  wire full_mode = conf_reg[`MBSR_C_MODE];
  wire use_soft = conf_reg[`MBSR_C_INPUT];
  wire in_one = use_soft ? conf_reg[`MBSR_C_SOFT_INPUT_ONE] : pin_one_s_reg;
  wire in_two = use_soft ? conf_reg[`MBSR_C_SOFT_INPUT_TWO] : sync2_reg[5];
  wire ov_live = fault_reg[`MBSR_B_OV];
  wire ov_prot = ov_live & full_mode & ~mask_reg[`MBSR_B_DOV];
  wire drive_ok = conf_reg[`MBSR_C_EN] & en_s & ~off_s;

  // Registered decode of every output-stage control.
  always @(posedge sys_clk) begin
    if (!rstn) begin
      out_enable <= 1'b0;
      out_one_high <= 1'b0;
      out_two_high <= 1'b0;
      ov_protect_active <= 1'b0;
      active_limit_on <= 1'b0;
      open_load_check_on <= 1'b0;
      open_load_test_start <= 1'b0;
      blanking_adjust_on <= 1'b0;
      independent_shorts <= 1'b0;
      current_limit_code <= 2'h0;
      slew_code <= 3'h0;
    end else begin
      out_enable <= drive_ok;
      ov_protect_active <= ov_prot;
      if (ov_prot) begin
        out_one_high <= 1'b1;
        out_two_high <= 1'b1;
      end else if (full_mode) begin
        out_one_high <= ~in_two | in_one;
        out_two_high <= ~(in_one & in_two);
      end else begin
        out_one_high <= in_one;
        out_two_high <= in_two;
      end
      active_limit_on <= conf_reg[`MBSR_C_AL] & full_mode;
      open_load_check_on <= conf_reg[`MBSR_C_CL] & full_mode;
      open_load_test_start <= conf_reg[`MBSR_C_CL] & ~cl_d_reg &
                              full_mode & ~drive_ok;
      blanking_adjust_on <= conf_reg[`MBSR_C_TM];
      independent_shorts <= ~full_mode;
      current_limit_code <= conf_reg[`MBSR_C_IL_HI:`MBSR_C_IL_LO];
      slew_code <= conf_reg[`MBSR_C_SR_HI:`MBSR_C_SR_LO];
    end
  end

  // Fault pin pulls low for any masked latched flag.
  assign fault_status_pin_n = ~|(flags_reg & mask_reg[11:0]);

endmodule // mbsr_regs

// *** test/mbsr_regs_asserts.sv ***
/*
  Port checker for the motor bridge register bank.
  Assumes the synchronous active-low reset and the 25 MHz system clock.
*/
`timescale 1ns/1ps
module mbsr_regs_asserts #(
  parameter PULSE_CYC = 25 // Least pin pulse in clocks.
) (
  input wire sys_clk, // System clock.
  input wire rstn, // Reset, active low.
  input wire spi_cs_n, // Frame select.
  input wire spi_miso_oe, // Reply pin driven.
  input wire enable_pin, // Enable pin.
  input wire output_off_pin, // Off pin.
  input wire fault_status_pin_n, // Fault pin.
  input wire out_enable, // Outputs driven.
  input wire out_one_high, // Output one high.
  input wire out_two_high, // Output two high.
  input wire ov_protect_active, // Overvoltage braking.
  input wire active_limit_on, // Limiting on.
  input wire open_load_check_on, // Open-load check on.
  input wire open_load_test_start, // Test start pulse.
  input wire independent_shorts, // Half-bridge handling.
  input wire [1:0] current_limit_code // Limit code.
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // A few cycles of a low enable pin must stop output control.
  property p_en_low; !enable_pin [*4] |=> !out_enable; endproperty
  a_en_low: assert property (p_en_low) else $error("outputs on, enable low");
  property p_off_high; output_off_pin [*4] |=> !out_enable; endproperty
  a_off_high: assert property (p_off_high) else $error("outputs on, off high");
  // Braking turns both high sides on, only in full-bridge mode.
  property p_ov_both; ov_protect_active |-> out_one_high && out_two_high;
  endproperty
  a_ov_both: assert property (p_ov_both) else $error("braking not both high");
  property p_ov_full; ov_protect_active |-> !independent_shorts; endproperty
  a_ov_full: assert property (p_ov_full) else $error("braking in half mode");
  property p_al_full; active_limit_on |-> !independent_shorts; endproperty
  a_al_full: assert property (p_al_full) else $error("limiting in half mode");
  property p_ol_full; open_load_check_on |-> !independent_shorts; endproperty
  a_ol_full: assert property (p_ol_full) else $error("open load in half mode");
  property p_ol_pulse;
    open_load_test_start |-> !independent_shorts ##1 !open_load_test_start;
  endproperty
  a_ol_pulse: assert property (p_ol_pulse) else $error("bad test start");
  property p_miso_off; spi_cs_n [*4] |=> !spi_miso_oe; endproperty
  a_miso_off: assert property (p_miso_off) else $error("reply pin driven idle");
  property p_rst_pin; $rose(rstn) |-> fault_status_pin_n; endproperty
  a_rst_pin: assert property (p_rst_pin) else $error("fault pin after reset");
  property p_code_hold;
    (spi_cs_n && rstn) [*8] |=> $stable(current_limit_code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code moved idle");
endmodule // mbsr_regs_asserts
bind mbsr_regs mbsr_regs_asserts #(.PULSE_CYC(PULSE_CYC)) chk_u (.sys_clk,
  .rstn, .spi_cs_n, .spi_miso_oe, .enable_pin, .output_off_pin,
  .fault_status_pin_n, .out_enable, .out_one_high, .out_two_high,
  .ov_protect_active, .active_limit_on, .open_load_check_on,
  .open_load_test_start, .independent_shorts, .current_limit_code);

// *** test/mbsr_host.sv ***
/*
  Host serial master model: mode 0, MSB first, clock idle low.
  Assumes the device replies within a few system clocks of each edge.
*/
`timescale 1ns/1ps
module mbsr_host (
  output logic spi_sclk, // Serial clock, 320 ns period.
  output logic spi_cs_n, // Frame select, active low.
  output logic spi_mosi, // Serial data out.
  input wire spi_miso // Serial data in.
);
  // Idle state: clock low, no frame.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // One frame of n clocks; the last 16 sampled bits come back.
  task automatic xfer(input logic [15:0] tx, input int n,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      spi_mosi = tx[i % 16];
      #160 spi_sclk = 1'b1;
      rx = {rx[14:0], spi_miso};
      #160 spi_sclk = 1'b0;
    end
    #160 spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // Released line must not look held.
    #400;
  endtask
endmodule // mbsr_host

// *** test/mbsr_regs_tb.sv ***
/*
  Self-checking bench for the motor bridge register bank.
  Assumes the host model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module mbsr_regs_tb;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic enable_pin = 1'b1;
  logic output_off_pin = 1'b0;
  logic drive_pin_one = 1'b0;
  logic drive_pin_two = 1'b0;
  logic [10:0] fault_raw = 11'h000;
  wire spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  wire fault_status_pin_n, out_enable, out_one_high, out_two_high;
  wire ov_protect_active, active_limit_on, open_load_check_on;
  wire open_load_test_start, blanking_adjust_on, independent_shorts;
  wire [1:0] current_limit_code;
  wire [2:0] slew_code;
  int mismatches = 0;
  int checks = 0;
  logic [15:0] rx, d;
  logic [12:0] mrst = 13'h06F1; // Mask reset value; the mask keeps it until the braking check writes it.
  // System clock, 40 ns period.
  always #20 sys_clk = ~sys_clk;
  mbsr_regs #(.PULSE_CYC(2)) dut_u (.sys_clk, .rstn, .spi_sclk, .spi_cs_n,
    .spi_mosi, .spi_miso, .spi_miso_oe, .enable_pin, .output_off_pin,
    .drive_pin_one, .drive_pin_two, .fault_raw, .fault_status_pin_n,
    .out_enable, .out_one_high, .out_two_high, .ov_protect_active,
    .active_limit_on, .open_load_check_on, .open_load_test_start,
    .blanking_adjust_on, .independent_shorts, .current_limit_code,
    .slew_code);
  mbsr_host host_u (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  // Compare and count.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("mismatches=%0d checks=%0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // A read returns the register chosen by the frame before.
  task automatic rd(input logic [1:0] s, output logic [15:0] v);
    host_u.xfer({1'b0, s, 13'h0000}, 16, v);
    host_u.xfer({1'b0, s, 13'h0000}, 16, v);
  endtask
  task automatic wr(input logic [15:0] v);
    host_u.xfer(v, 16, rx);
  endtask
  // Expected {two, one} output levels from pins or virtual bits.
  function automatic logic [1:0] outs(logic [12:0] c, logic a, logic b);
    logic x, y;
    x = c[2] ? c[0] : a;
    y = c[2] ? c[1] : b;
    return c[3] ? {~(x & y), x | ~y} : {y, x};
  endfunction
  // Drive pins at the falling edge.
  task automatic pins(input logic [3:0] v);
    @(negedge sys_clk);
    {enable_pin, output_off_pin, drive_pin_one, drive_pin_two} = v;
    repeat (4) @(negedge sys_clk);
  endtask
  // Hang guard.
  initial begin
    #3ms;
    mismatches++;
    results;
  end
  // Main sequence.
  initial begin
    d = 16'($urandom(32'h9E6B));
    repeat (6) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(2'h2, rx);
    chk(rx, 16'h46F1);
    rd(2'h3, rx);
    chk(rx, 16'h6D98);
    for (int i = 0; i < 16; i++) begin
      d = 16'($urandom);
      pins(d[15:12]);
      wr({3'h7, d[12:0]});
      rd(2'h3, rx);
      chk(rx, {3'h3, d[12:0]});
      chk({4'h0, slew_code, current_limit_code, out_two_high, out_one_high,
        out_enable, independent_shorts, blanking_adjust_on, active_limit_on,
        open_load_check_on}, {4'h0, d[7:5], d[9:8],
        outs(d[12:0], drive_pin_one, drive_pin_two),
        d[4] & enable_pin & ~output_off_pin, ~d[3], d[11], d[10] & d[3],
        d[12] & d[3]});
    end
    pins(4'h8);
    for (int b = 0; b < 11; b++) begin
      @(negedge sys_clk);
      fault_raw = 11'h001 << b;
      wr(16'hBFFF);
      rd(2'h1, rx);
      chk(rx, 16'h2000 | (16'h0001 << b));
      chk({15'h0000, fault_status_pin_n}, {15'h0000, ~mrst[b]});
      @(negedge sys_clk);
      fault_raw = 11'h000;
      wr(16'hA000);
      rd(2'h1, rx);
      chk(rx, 16'h2000 | (16'h0001 << b));
      wr(16'hBFFF);
      rd(2'h1, rx);
      chk(rx, 16'h2000);
    end
    wr(16'h8000);
    rd(2'h1, rx);
    chk(rx, 16'h2800);
    pins(4'h0);
    pins(4'h8);
    rd(2'h1, rx);
    chk(rx, 16'h2000);
    host_u.xfer(16'h0000, 8, rx);
    rd(2'h1, rx);
    chk(rx, 16'h2800);
    pins(4'hC);
    pins(4'h8);
    rd(2'h1, rx);
    chk(rx, 16'h2000);
    wr(16'hC000);
    wr(16'hE018);
    @(negedge sys_clk);
    fault_raw = 11'h100;
    repeat (6) @(negedge sys_clk);
    chk({15'h0000, ov_protect_active}, 16'h0001);
    wr(16'hD000);
    chk({15'h0000, ov_protect_active}, 16'h0000);
    results;
  end
endmodule // mbsr_regs_tb
